// ==== rtl/ccl_pkg.sv ====
package ccl_pkg;

	localparam int CCL_AW = 12;
	localparam int CCL_DW = 32;

	// Printed register indices, byte address is index times four
	localparam logic [7:0] CCL_CTRL_IDX = 8'h9B;
	localparam logic [7:0] CCL_MODE_IDX = 8'h9D;
	localparam logic [11:0] CCL_CTRL_ADDR = {2'h0, CCL_CTRL_IDX, 2'h0};
	localparam logic [11:0] CCL_MODE_ADDR = {2'h0, CCL_MODE_IDX, 2'h0};
	localparam logic [11:0] CCL_STAT_ADDR = 12'h280;
	localparam logic [11:0] CCL_CLR_ADDR = 12'h284;
	localparam logic [11:0] CCL_IEN_ADDR = 12'h288;

	localparam int CCL_ON_BIT = 7;
	localparam int CCL_LVL_BIT = 6;
	localparam int CCL_RISE_BIT = 5;
	localparam int CCL_FALL_BIT = 4;
	localparam int CCL_HYP_LSB = 2;
	localparam int CCL_HYN_LSB = 0;
	localparam int CCL_MD_LSB = 0;

	typedef enum logic [1:0] {
		CCL_HYST_OFF = 2'h0,
		CCL_HYST_5MV = 2'h1,
		CCL_HYST_10MV = 2'h2,
		CCL_HYST_20MV = 2'h3
	} ccl_hyst_t;

	typedef enum logic [1:0] {
		CCL_RESP_FAST = 2'h0,
		CCL_RESP_MID1 = 2'h1,
		CCL_RESP_MID2 = 2'h2,
		CCL_RESP_SLOW = 2'h3
	} ccl_resp_t;

	localparam ccl_resp_t CCL_MD_RST = CCL_RESP_MID2;
	localparam ccl_hyst_t CCL_HYST_RST = CCL_HYST_OFF;
	localparam int CCL_SYNC_LAT = 3;

endpackage

// ==== rtl/ccl_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none

module ccl_sync2 (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Level crossing
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} ccl_sync_st_t;

	ccl_sync_st_t st;
	ccl_sync_st_t next_st;

	always_comb begin
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign sync_out = st.s2;

endmodule

`default_nettype wire

// ==== rtl/ccl_edge_flag.sv ====
`timescale 1ns/1ns
`default_nettype none

module ccl_edge_flag (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Set and clear requests
	input wire logic set_evt,
	input wire logic clr_req,
	output logic flag
);
	typedef struct packed {
		logic flag;
	} ccl_flag_st_t;

	ccl_flag_st_t st;
	ccl_flag_st_t next_st;

	// Set wins over a clear in the same cycle
	always_comb begin
		next_st.flag = set_evt | (st.flag & ~clr_req);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign flag = st.flag;

endmodule

`default_nettype wire

// ==== rtl/ccl_cmp_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

module ccl_cmp_ctrl (
	// System
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,

	// APB slave
	input wire logic [ccl_pkg::CCL_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ccl_pkg::CCL_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [ccl_pkg::CCL_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,

	// Analog stage
	input wire logic cmp_in,
	output logic cmp_power_en,
	output ccl_pkg::ccl_hyst_t pos_hyst_sel,
	output ccl_pkg::ccl_hyst_t neg_hyst_sel,
	output ccl_pkg::ccl_resp_t response_time_sel,

	// Crossbar
	output logic cmp_sync_out,
	output logic cmp_raw_out,

	// Interrupt
	output logic irq
);
	import ccl_pkg::*;

	typedef struct packed {
		logic on;
		logic rie;
		logic fie;
		ccl_hyst_t hyp;
		ccl_hyst_t hyn;
		ccl_resp_t md;
		logic level;
		logic irq;
		logic rdy;
		logic err;
		logic [CCL_DW-1:0] rdata;
	} ccl_state_t;

	ccl_state_t st;
	ccl_state_t next_st;

	logic cmp_s;
	logic rise_flag;
	logic fall_flag;
	logic rise_set;
	logic fall_set;
	logic rise_clr;
	logic fall_clr;
	logic acc;
	logic wr;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_clr;
	logic wr_ien;

	// Comparator decision into the clock domain
	ccl_sync2 u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.async_in(cmp_in),
		.sync_out(cmp_s)
	);

	// Access phase; writes land on the pready edge
	assign acc = psel & penable;

	assign wr = acc & st.rdy & pwrite & pstrb[0];

	assign wr_ctrl = wr & (paddr == CCL_CTRL_ADDR);

	assign wr_mode = wr & (paddr == CCL_MODE_ADDR);

	assign wr_clr = wr & (paddr == CCL_CLR_ADDR);

	assign wr_ien = wr & (paddr == CCL_IEN_ADDR);

	// Edges seen on the gated, synced level
	assign rise_set = next_st.level & ~st.level;

	assign fall_set = ~next_st.level & st.level;

	// Zero in control or one in clear register
	assign rise_clr = (wr_ctrl & ~pwdata[CCL_RISE_BIT])
		| (wr_clr & pwdata[CCL_RISE_BIT]);

	assign fall_clr = (wr_ctrl & ~pwdata[CCL_FALL_BIT])
		| (wr_clr & pwdata[CCL_FALL_BIT]);

	ccl_edge_flag u_rise (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set_evt(rise_set),
		.clr_req(rise_clr),
		.flag(rise_flag)
	);

	ccl_edge_flag u_fall (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set_evt(fall_set),
		.clr_req(fall_clr),
		.flag(fall_flag)
	);

	always_comb begin
		next_st = st;

		// Control register fields
		if (wr_ctrl) begin
			next_st.on = pwdata[CCL_ON_BIT];
			next_st.hyp = ccl_hyst_t'(pwdata[CCL_HYP_LSB +: 2]);
			next_st.hyn = ccl_hyst_t'(pwdata[CCL_HYN_LSB +: 2]);
		end

		// Mode register fields
		if (wr_mode) begin
			next_st.rie = pwdata[CCL_RISE_BIT];
			next_st.fie = pwdata[CCL_FALL_BIT];
			next_st.md = ccl_resp_t'(pwdata[CCL_MD_LSB +: 2]);
		end

		// Enable register aliases the mode enables
		if (wr_ien) begin
			next_st.rie = pwdata[CCL_RISE_BIT];
			next_st.fie = pwdata[CCL_FALL_BIT];
		end

		// Off forces the level low in the same edge
		next_st.level = cmp_s & next_st.on;

		// Level interrupt from masked sticky flags
		next_st.irq = (rise_flag & st.rie)
			| (fall_flag & st.fie);

		// One wait state, then pready for one cycle
		next_st.rdy = 1'b0;
		next_st.err = 1'b0;
		next_st.rdata = '0;

		if (acc & ~st.rdy) begin
			next_st.rdy = 1'b1;
			if (paddr == CCL_CTRL_ADDR) begin
				next_st.rdata[CCL_ON_BIT] = st.on;
				next_st.rdata[CCL_LVL_BIT] = st.level;
				next_st.rdata[CCL_RISE_BIT] = rise_flag;
				next_st.rdata[CCL_FALL_BIT] = fall_flag;
				next_st.rdata[CCL_HYP_LSB +: 2] = st.hyp;
				next_st.rdata[CCL_HYN_LSB +: 2] = st.hyn;
			end else if (paddr == CCL_MODE_ADDR) begin
				next_st.rdata[CCL_RISE_BIT] = st.rie;
				next_st.rdata[CCL_FALL_BIT] = st.fie;
				next_st.rdata[CCL_MD_LSB +: 2] = st.md;
			end else if (paddr == CCL_STAT_ADDR) begin
				next_st.rdata[CCL_RISE_BIT] = rise_flag;
				next_st.rdata[CCL_FALL_BIT] = fall_flag;
			end else if (paddr == CCL_IEN_ADDR) begin
				next_st.rdata[CCL_RISE_BIT] = st.rie;
				next_st.rdata[CCL_FALL_BIT] = st.fie;
			end else if (paddr == CCL_CLR_ADDR) begin
				next_st.rdata = '0;
			end else begin
				next_st.err = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.md <= CCL_MD_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Raw path has no flop so it runs without a clock
	assign cmp_raw_out = cmp_in & st.on;

	assign cmp_sync_out = st.level;

	assign cmp_power_en = st.on;

	assign pos_hyst_sel = st.hyp;

	assign neg_hyst_sel = st.hyn;

	assign response_time_sel = st.md;

	assign irq = st.irq;

	assign prdata = st.rdata;

	assign pready = st.rdy;

	assign pslverr = st.err;

	default clocking cb @(posedge pclk);
	endclocking

	default disable iff (!presetn);

	sync_out_lag_a: assert property (
		$past(ce, 1) && $past(ce, 2) && $past(ce, 3)
		&& cmp_power_en && $past(cmp_power_en, 1)
		|-> cmp_sync_out == $past(cmp_in, 3)
	) else $error("synced output does not track input");

	off_outputs_low_a: assert property (
		!cmp_power_en |-> !cmp_sync_out && !cmp_raw_out
	) else $error("output not low while disabled");

	enable_write_a: assert property (
		ce && wr_ctrl
		|=> cmp_power_en == $past(pwdata[CCL_ON_BIT])
	) else $error("enable bit write not applied");

	level_read_a: assert property (
		ce && acc && !st.rdy && !pwrite
		&& paddr == CCL_CTRL_ADDR
		|=> prdata[CCL_LVL_BIT] == $past(cmp_sync_out)
	) else $error("level bit read wrong");

	fall_sets_flag_a: assert property (
		ce && cmp_sync_out && !next_st.level
		|=> fall_flag
	) else $error("falling edge did not set flag");

	rise_sets_flag_a: assert property (
		ce && !cmp_sync_out && next_st.level
		|=> rise_flag
	) else $error("rising edge did not set flag");

	flag_holds_a: assert property (
		rise_flag && !rise_clr |=> rise_flag
	) else $error("rising flag dropped without clear");

	rise_masked_a: assert property (
		ce && !st.rie && !fall_flag |=> !irq
	) else $error("masked rising flag raised irq");

	fall_masked_a: assert property (
		ce && !st.fie && !rise_flag |=> !irq
	) else $error("masked falling flag raised irq");

	hyst_write_a: assert property (
		ce && wr_ctrl
		|=> pos_hyst_sel == $past(pwdata[3:2])
		&& neg_hyst_sel == $past(pwdata[1:0])
	) else $error("hysteresis fields not written");

	resp_write_a: assert property (
		ce && wr_mode
		|=> response_time_sel == $past(pwdata[1:0])
	) else $error("response time not written");

	irq_follows_a: assert property (
		ce && rise_flag && st.rie |=> irq
	) else $error("enabled flag did not raise irq");

	edge_beats_clear_a: assert property (
		ce && rise_set && rise_clr |=> rise_flag
	) else $error("clear won over simultaneous edge");

	fall_holds_a: assert property (
		fall_flag && !fall_clr |=> fall_flag
	) else $error("falling flag dropped without clear");

	fall_beats_clear_a: assert property (
		ce && fall_set && fall_clr |=> fall_flag
	) else $error("clear won over simultaneous fall");

	// Bus answer timing
	ready_wait_a: assert property (
		ce && acc && !pready |=> pready
	) else $error("no ready after one wait state");

	ready_pulse_a: assert property (
		ce && pready |=> !pready
	) else $error("ready held longer than one cycle");

	unmapped_error_a: assert property (
		ce && acc && !pready && paddr != CCL_CTRL_ADDR && paddr != CCL_MODE_ADDR
		&& paddr != CCL_STAT_ADDR && paddr != CCL_CLR_ADDR
		&& paddr != CCL_IEN_ADDR |=> pslverr
	) else $error("unmapped access gave no error");

	error_with_ready_a: assert property (
		pslverr |-> pready
	) else $error("error raised without ready");

	idle_rdata_zero_a: assert property (
		!pready |-> prdata == '0
	) else $error("read data not zero outside answer");

	// Flag clearing paths
	clear_reg_fall_a: assert property (
		ce && wr_clr && pwdata[CCL_FALL_BIT] && !fall_set
		|=> !fall_flag
	) else $error("clear register did not clear flag");

	ctrl_clear_rise_a: assert property (
		ce && wr_ctrl && !pwdata[CCL_RISE_BIT] && !rise_set
		|=> !rise_flag
	) else $error("zero write did not clear flag");

	fall_irq_a: assert property (
		ce && fall_flag && st.fie |=> irq
	) else $error("enabled falling flag gave no irq");

	irq_drops_a: assert property (
		ce && !rise_flag && !fall_flag |=> !irq
	) else $error("irq high with no flag set");

	ien_write_a: assert property (
		ce && wr_ien
		|=> st.rie == $past(pwdata[CCL_RISE_BIT])
		&& st.fie == $past(pwdata[CCL_FALL_BIT])
	) else $error("enable register write not applied");

	strobe_gates_a: assert property (
		ce && acc && pready && pwrite && !pstrb[0]
		|=> $stable(cmp_power_en) && $stable(response_time_sel)
		&& $stable(pos_hyst_sel)
	) else $error("write without strobe changed a field");

endmodule

`default_nettype wire

// ==== tb/ccl_analog_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module ccl_analog_model (
	// Control from the block
	input wire logic power_en,
	// Bench-set input polarity
	input wire logic want_high,
	// Decision to the block
	output logic cmp_in
);
	// Unpowered stage settles low
	assign cmp_in = power_en & want_high;
endmodule

`default_nettype wire

// ==== tb/ccl_cmp_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module ccl_cmp_ctrl_bench;
	import ccl_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, cmp_in, pwr, sync_o, raw_o, irq;
	ccl_hyst_t hp, hn;
	ccl_resp_t rs;
	logic [32:0] exp_q[$];
	logic [7:0] h;
	int n_fail = 0, checks_done = 0;

	always #25 pclk = ~pclk;

	ccl_cmp_ctrl ccl_cmp_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_in(cmp_in), .cmp_power_en(pwr), .pos_hyst_sel(hp), .neg_hyst_sel(hn),
		.response_time_sel(rs), .cmp_sync_out(sync_o), .cmp_raw_out(raw_o), .irq(irq));
	ccl_analog_model ccl_analog_model_inst (.power_en(pwr), .want_high(want), .cmp_in(cmp_in));

	task automatic chk(input logic [32:0] got, input logic [32:0] e);
		checks_done++;
		if (got !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	// Power, raw, synced, irq, hysteresis, response
	task automatic chk_out(input logic [9:0] e);
		chk({23'h0, pwr, raw_o, sync_o, irq, hp, hn, rs}, {23'h0, e});
	endtask

	// Read results taken at the pready edge
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
		paddr <= a;
		pwrite <= wr;
		pwdata <= {24'h0, d};
		psel <= 1'b1;
		if (!wr)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic w(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic r(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h0, {25'h0, e});
	endtask

	task automatic final_report;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		final_report;
	end

	initial begin
		void'($urandom(43397));
		h = 8'($urandom() & 32'hF);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_out(10'h002);
		r(CCL_CTRL_ADDR, 8'h00);
		r(CCL_MODE_ADDR, 8'h02);
		w(CCL_CTRL_ADDR, 8'h80 | h);
		w(CCL_CTRL_ADDR, 8'h80 | h);
		want <= 1'b1;
		repeat (5) @(posedge pclk);
		chk_out({4'b1110, h[3:0], 2'h2});
		r(CCL_CTRL_ADDR, 8'hE0 | h);
		ce <= 1'b0;
		want <= 1'b0;
		repeat (5) @(posedge pclk);
		chk_out({4'b1010, h[3:0], 2'h2});
		want <= 1'b1;
		ce <= 1'b1;
		repeat (5) @(posedge pclk);
		for (int i = 0; i < 4; i++) begin
			w(CCL_MODE_ADDR, 8'h30 | i[7:0]);
			repeat (2) @(posedge pclk);
			chk_out({4'b1111, h[3:0], i[1:0]});
		end
		w(CCL_CTRL_ADDR, 8'h80 | h);
		repeat (2) @(posedge pclk);
		chk_out({4'b1110, h[3:0], 2'h3});
		r(CCL_STAT_ADDR, 8'h00);
		want <= 1'b0;
		repeat (5) @(posedge pclk);
		chk_out({4'b1001, h[3:0], 2'h3});
		w(CCL_CTRL_ADDR, 8'hB0 | h);
		r(CCL_CTRL_ADDR, 8'h90 | h);
		w(CCL_IEN_ADDR, 8'h20);
		repeat (2) @(posedge pclk);
		chk_out({4'b1000, h[3:0], 2'h3});
		r(CCL_MODE_ADDR, 8'h23);
		r(CCL_STAT_ADDR, 8'h10);
		w(CCL_CLR_ADDR, 8'h10);
		r(CCL_STAT_ADDR, 8'h00);
		r(CCL_CLR_ADDR, 8'h00);
		want <= 1'b1;
		repeat (5) @(posedge pclk);
		w(CCL_CTRL_ADDR, 8'h20 | h);
		repeat (5) @(posedge pclk);
		chk_out({4'b0001, h[3:0], 2'h3});
		r(CCL_CTRL_ADDR, 8'h30 | h);
		pstrb <= 4'h0;
		w(CCL_MODE_ADDR, 8'h00);
		pstrb <= 4'hF;
		r(CCL_MODE_ADDR, 8'h23);
		apb(1'b0, 12'h100, 8'h0, {1'b1, 32'h0});
		final_report;
	end
endmodule

`default_nettype wire
